// [vcr_pkg.sv]
// vcr_pkg: map, field layout and state types of the analog channel register bank
package vcr_pkg;

  localparam int NUM_REGS = 11;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLOCK_CFG  = 8'hC0;
  localparam logic [7:0] IDX_PHASE_1_4  = 8'hC1;
  localparam logic [7:0] IDX_PHASE_5_8  = 8'hC2;
  localparam logic [7:0] IDX_PHASE_9_12 = 8'hC3;
  localparam logic [7:0] IDX_PHASE_13_16 = 8'hC4;
  localparam logic [7:0] IDX_CHAN_PDN   = 8'hC5;
  localparam logic [7:0] IDX_GLOBAL_PDN = 8'hC6;
  localparam logic [7:0] IDX_FILTER_CFG = 8'hC7;
  localparam logic [7:0] IDX_LOW_POWER  = 8'hC8;
  localparam logic [7:0] IDX_MED_POWER  = 8'hCE;
  localparam logic [7:0] IDX_SWITCH_DIS = 8'hE6;

  // storage slots
  localparam logic [3:0] SLOT_CLOCK_CFG  = 4'h0;
  localparam logic [3:0] SLOT_PHASE_1_4  = 4'h1;
  localparam logic [3:0] SLOT_PHASE_5_8  = 4'h2;
  localparam logic [3:0] SLOT_PHASE_9_12 = 4'h3;
  localparam logic [3:0] SLOT_PHASE_13_16 = 4'h4;
  localparam logic [3:0] SLOT_CHAN_PDN   = 4'h5;
  localparam logic [3:0] SLOT_GLOBAL_PDN = 4'h6;
  localparam logic [3:0] SLOT_FILTER_CFG = 4'h7;
  localparam logic [3:0] SLOT_LOW_POWER  = 4'h8;
  localparam logic [3:0] SLOT_MED_POWER  = 4'h9;
  localparam logic [3:0] SLOT_SWITCH_DIS = 4'hA;

  localparam logic [15:0] REG_RESET = 16'h0000;
  // implemented bits per slot, slot 0 in the low word
  localparam logic [NUM_REGS-1:0][15:0] REG_MASK = {
    16'h001F, 16'h4000, 16'h1000, 16'h0F80, 16'h000F,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h001F};

  // field positions
  localparam int BIT_PATH_SEL  = 0;
  localparam int BIT_RATIO_LO  = 1;
  localparam int BIT_FAST_TYPE = 3;
  localparam int BIT_BASE_TYPE = 4;
  localparam int BIT_FAST_PDN  = 0;
  localparam int BIT_GLOBAL_PDN = 1;
  localparam int BIT_LNA_PDN   = 2;
  localparam int BIT_FILT_PDN  = 3;
  localparam int BIT_LPF_LO    = 7;
  localparam int BIT_HPF_DIS   = 9;
  localparam int BIT_HPF_LO    = 10;
  localparam int BIT_LOW_POWER = 12;
  localparam int BIT_MED_POWER = 14;
  localparam int BIT_EXT_SW_DIS = 4;
  localparam int PHASE_BITS    = 4;

  localparam logic [1:0] HSIZE_WORD = 2'h2;

  typedef enum logic {VCR_IDLE, VCR_DATA} vcr_phase_t;

  typedef struct packed {
    vcr_phase_t  phase;
    logic        write;
    logic [3:0]  slot;
    logic        ready;
    logic [31:0] rdata;
  } vcr_port_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][15:0] regs;
    logic                      tgc_active;
    logic                      lna_gain_fixed;
    logic                      attenuator_disable;
    logic                      lowpass_disable;
  } vcr_bank_t;

  // byte address to storage slot, SLOT_NONE when unmapped
  function automatic logic [3:0] slot_of(input logic [31:0] addr);
    logic [3:0] s;
    s = SLOT_NONE;
    if (addr[31:10] == 22'h000000)
    begin
      unique case (addr[9:2])
        IDX_CLOCK_CFG:   s = SLOT_CLOCK_CFG;
        IDX_PHASE_1_4:   s = SLOT_PHASE_1_4;
        IDX_PHASE_5_8:   s = SLOT_PHASE_5_8;
        IDX_PHASE_9_12:  s = SLOT_PHASE_9_12;
        IDX_PHASE_13_16: s = SLOT_PHASE_13_16;
        IDX_CHAN_PDN:    s = SLOT_CHAN_PDN;
        IDX_GLOBAL_PDN:  s = SLOT_GLOBAL_PDN;
        IDX_FILTER_CFG:  s = SLOT_FILTER_CFG;
        IDX_LOW_POWER:   s = SLOT_LOW_POWER;
        IDX_MED_POWER:   s = SLOT_MED_POWER;
        IDX_SWITCH_DIS:  s = SLOT_SWITCH_DIS;
        default:         s = SLOT_NONE;
      endcase
    end
    return s;
  endfunction

  // mixer phase code of one channel, 0-based, in steps of 22.5 degrees
  function automatic logic [3:0] phase_of(input logic [63:0] ph, input logic [3:0] ch);
    return ph[ch*PHASE_BITS +: PHASE_BITS];
  endfunction

endpackage

// [vcr_reg_if.sv]
// vcr_reg_if: register access strobe between bus port and register storage
`timescale 1ns/1ps
interface vcr_reg_if;
  logic        wr;
  logic [3:0]  slot;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport port (output wr, output slot, output wdata, input rdata);
  modport bank (input wr, input slot, input wdata, output rdata);
endinterface

// [vcr_ahb_port.sv]
// vcr_ahb_port: AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
module vcr_ahb_port (
  input  wire logic        i_clk,       // system clock
  input  wire logic        i_srst,      // synchronous reset
  input  wire logic        i_hsel,      // slave select
  input  wire logic [31:0] i_haddr,     // byte address
  input  wire logic [1:0]  i_htrans,    // transfer type
  input  wire logic        i_hwrite,    // write when high
  input  wire logic [2:0]  i_hsize,     // transfer size
  input  wire logic [31:0] i_hwdata,    // write data
  input  wire logic        i_hready,    // bus ready
  output logic             o_hreadyout, // slave ready
  output logic             o_hresp,     // always okay
  output logic [31:0]      o_hrdata,    // read data
  vcr_reg_if.port          bus          // to storage
);

  vcr_pkg::vcr_port_t st;
  vcr_pkg::vcr_port_t next_st;

  always_comb
  begin
    next_st = st;
    unique case (st.phase)
      vcr_pkg::VCR_IDLE:
      begin
        if (i_hsel && i_htrans[1] && i_hready)
        begin
          next_st.phase = vcr_pkg::VCR_DATA;
          // only whole-word writes reach the storage
          next_st.write = i_hwrite && (i_hsize == {1'b0, vcr_pkg::HSIZE_WORD});
          next_st.slot  = vcr_pkg::slot_of(i_haddr);
          next_st.ready = 1'b0;
        end
      end
      vcr_pkg::VCR_DATA:
      begin
        // the wait state gives hwdata time to settle and hrdata a flop
        next_st.phase = vcr_pkg::VCR_IDLE;
        next_st.ready = 1'b1;
        next_st.rdata = st.write ? 32'h00000000 : {16'h0000, bus.rdata};
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st <= '{phase: vcr_pkg::VCR_IDLE, write: 1'b0, slot: vcr_pkg::SLOT_NONE,
              ready: 1'b1, rdata: 32'h00000000};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.wr      = (st.phase == vcr_pkg::VCR_DATA) && st.write;
  assign bus.slot    = st.slot;
  assign bus.wdata   = i_hwdata[15:0];
  assign o_hreadyout = st.ready;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st.rdata;

endmodule

// [vcr_bank.sv]
// vcr_bank: analog channel control register bank behind an AHB-Lite port
// Operation
// - every register resets to zero
// - bit 4: base clock buffer CMOS/differential
// - bit 3: fast clock buffer differential/CMOS
// - bits 2-1: clock ratio 16X/8X/4X/1X
// - bit 0: TGC or CW path, exclusive
// - CW forces fixed 18 dB gain, no attenuator/filter
// - phase code N means N times 22.5 degrees
// - 0xC1 holds channels 1-4, channel 1 low
// - 0xC2-0xC4 hold channels 5-16 likewise
// - 0xC5 bit per channel powers analog channel down
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module vcr_bank (
  input  wire logic        i_clk,                        // 100 MHz clock
  input  wire logic        i_srst,                       // synchronous reset
  input  wire logic        i_hsel,                       // AHB select
  input  wire logic [31:0] i_haddr,                      // AHB address
  input  wire logic [1:0]  i_htrans,                     // AHB transfer type
  input  wire logic        i_hwrite,                     // AHB direction
  input  wire logic [2:0]  i_hsize,                      // AHB size
  input  wire logic [31:0] i_hwdata,                     // AHB write data
  input  wire logic        i_hready,                     // AHB ready in
  output logic             o_hreadyout,                  // AHB ready out
  output logic             o_hresp,                      // AHB response
  output logic [31:0]      o_hrdata,                     // AHB read data
  output logic             o_signal_path_select,         // 1 = CW path
  output logic             o_tgc_active,                 // TGC path on
  output logic [1:0]       o_doppler_clock_ratio,        // CW clock ratio
  output logic             o_base_rate_clock_input_type, // 1 = differential
  output logic             o_fast_rate_clock_input_type, // 1 = CMOS
  output logic             o_lna_gain_fixed,             // LNA held at 18 dB
  output logic             o_attenuator_disable,         // input attenuator off
  output logic             o_lowpass_disable,            // low-pass filter off
  output logic [63:0]      o_mixer_phase,                // 4 bits per channel
  output logic [15:0]      o_channel_powerdown,          // per channel
  output logic             o_fast_powerdown,             // fast power-down
  output logic             o_global_powerdown,           // global power-down
  output logic             o_lna_powerdown,              // LNA power-down
  output logic             o_filter_powerdown,           // filter power-down
  output logic [1:0]       o_lowpass_corner,             // filter corner code
  output logic             o_lna_highpass_disable,       // LNA high-pass off
  output logic [1:0]       o_lna_highpass_corner,        // LNA high-pass code
  output logic             o_low_power_mode,             // low-power setting
  output logic             o_medium_power_mode,          // medium-power setting
  output logic [3:0]       o_switch_disable,             // T/R switch disables
  output logic             o_ext_switch_disable          // external switch off
);

  vcr_reg_if bus ();

  vcr_ahb_port u_port (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .o_hrdata    (o_hrdata),
    .bus         (bus.port)
  );

  vcr_pkg::vcr_bank_t st;
  vcr_pkg::vcr_bank_t next_st;
  logic               slot_ok;

  assign slot_ok = (bus.slot < 4'(vcr_pkg::NUM_REGS));

  // the write gate of the gain memory lives elsewhere; software owns it
  always_comb
  begin
    next_st = st;
    if (bus.wr && slot_ok)
    begin
      // unimplemented bits are dropped so they read back as zero
      next_st.regs[bus.slot] = bus.wdata & vcr_pkg::REG_MASK[bus.slot];
    end
    // derived from the new value so the path controls move with the write
    next_st.tgc_active = !next_st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_PATH_SEL];
    next_st.lna_gain_fixed =
      next_st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_PATH_SEL];
    next_st.attenuator_disable =
      next_st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_PATH_SEL];
    next_st.lowpass_disable =
      next_st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_PATH_SEL];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st <= '{regs: {vcr_pkg::NUM_REGS{vcr_pkg::REG_RESET}}, tgc_active: 1'b1,
              lna_gain_fixed: 1'b0, attenuator_disable: 1'b0,
              lowpass_disable: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.rdata = slot_ok ? st.regs[bus.slot] : 16'h0000;

  // field outputs, each a direct flop bit
  assign o_signal_path_select =
    st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_PATH_SEL];
  assign o_tgc_active = st.tgc_active;
  assign o_doppler_clock_ratio =
    st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_RATIO_LO +: 2];
  assign o_base_rate_clock_input_type =
    st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_BASE_TYPE];
  assign o_fast_rate_clock_input_type =
    st.regs[vcr_pkg::SLOT_CLOCK_CFG][vcr_pkg::BIT_FAST_TYPE];
  assign o_lna_gain_fixed     = st.lna_gain_fixed;
  assign o_attenuator_disable = st.attenuator_disable;
  assign o_lowpass_disable    = st.lowpass_disable;
  // channel 1 sits in the lowest nibble; code N is N x 22.5 degrees
  assign o_mixer_phase = {st.regs[vcr_pkg::SLOT_PHASE_13_16],
                          st.regs[vcr_pkg::SLOT_PHASE_9_12],
                          st.regs[vcr_pkg::SLOT_PHASE_5_8],
                          st.regs[vcr_pkg::SLOT_PHASE_1_4]};
  // analog channel only; converter power is controlled elsewhere
  assign o_channel_powerdown = st.regs[vcr_pkg::SLOT_CHAN_PDN];
  assign o_fast_powerdown =
    st.regs[vcr_pkg::SLOT_GLOBAL_PDN][vcr_pkg::BIT_FAST_PDN];
  assign o_global_powerdown =
    st.regs[vcr_pkg::SLOT_GLOBAL_PDN][vcr_pkg::BIT_GLOBAL_PDN];
  assign o_lna_powerdown =
    st.regs[vcr_pkg::SLOT_GLOBAL_PDN][vcr_pkg::BIT_LNA_PDN];
  assign o_filter_powerdown =
    st.regs[vcr_pkg::SLOT_GLOBAL_PDN][vcr_pkg::BIT_FILT_PDN];
  assign o_lowpass_corner =
    st.regs[vcr_pkg::SLOT_FILTER_CFG][vcr_pkg::BIT_LPF_LO +: 2];
  assign o_lna_highpass_disable =
    st.regs[vcr_pkg::SLOT_FILTER_CFG][vcr_pkg::BIT_HPF_DIS];
  assign o_lna_highpass_corner =
    st.regs[vcr_pkg::SLOT_FILTER_CFG][vcr_pkg::BIT_HPF_LO +: 2];
  assign o_low_power_mode =
    st.regs[vcr_pkg::SLOT_LOW_POWER][vcr_pkg::BIT_LOW_POWER];
  assign o_medium_power_mode =
    st.regs[vcr_pkg::SLOT_MED_POWER][vcr_pkg::BIT_MED_POWER];
  assign o_switch_disable = st.regs[vcr_pkg::SLOT_SWITCH_DIS][3:0];
  assign o_ext_switch_disable =
    st.regs[vcr_pkg::SLOT_SWITCH_DIS][vcr_pkg::BIT_EXT_SW_DIS];

  // ---- checks ----
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  logic wr_clk;
  logic wr_pdn;
  assign wr_clk = bus.wr && (bus.slot == vcr_pkg::SLOT_CLOCK_CFG);
  assign wr_pdn = bus.wr && (bus.slot == vcr_pkg::SLOT_CHAN_PDN);

  reset_zero_a: assert property (
    $past(i_srst) |-> (o_mixer_phase == 64'h0000000000000000) &&
      (o_channel_powerdown == 16'h0000) && !o_signal_path_select &&
      (o_doppler_clock_ratio == 2'h0) && !o_low_power_mode)
    else $error("bank not zero after reset");

  base_clk_type_a: assert property (
    wr_clk |=> o_base_rate_clock_input_type == $past(bus.wdata[4]))
    else $error("base clock input type not taken from bit 4");

  fast_clk_type_a: assert property (
    wr_clk |=> o_fast_rate_clock_input_type == $past(bus.wdata[3]))
    else $error("fast clock input type not taken from bit 3");

  clock_ratio_a: assert property (
    wr_clk |=> o_doppler_clock_ratio == $past(bus.wdata[2:1]))
    else $error("clock ratio not taken from bits 2-1");

  path_excl_a: assert property (
    o_tgc_active != o_signal_path_select)
    else $error("TGC and CW paths active together");

  cw_forces_a: assert property (
    o_lna_gain_fixed == o_signal_path_select &&
    o_attenuator_disable == o_signal_path_select &&
    o_lowpass_disable == o_signal_path_select)
    else $error("CW mode overrides wrong");

  phase_low_a: assert property (
    bus.wr && bus.slot == vcr_pkg::SLOT_PHASE_1_4 |=>
      vcr_pkg::phase_of(o_mixer_phase, 4'h0) == $past(bus.wdata[3:0]) &&
      vcr_pkg::phase_of(o_mixer_phase, 4'h3) == $past(bus.wdata[15:12]))
    else $error("channel 1 or 4 phase misplaced");

  phase_high_a: assert property (
    bus.wr && bus.slot == vcr_pkg::SLOT_PHASE_13_16 |=>
      vcr_pkg::phase_of(o_mixer_phase, 4'hF) == $past(bus.wdata[15:12]) &&
      vcr_pkg::phase_of(o_mixer_phase, 4'hC) == $past(bus.wdata[3:0]))
    else $error("channel 13 or 16 phase misplaced");

  chan_pdn_a: assert property (
    wr_pdn |=> o_channel_powerdown == $past(bus.wdata))
    else $error("channel power-down not stored");

  hold_value_a: assert property (
    !bus.wr |=> $stable(o_mixer_phase) && $stable(o_channel_powerdown) &&
      $stable(o_signal_path_select))
    else $error("field changed without a write");

  bus_answer_a: assert property (
    i_hsel && i_htrans[1] && i_hready |=> !o_hreadyout ##1 o_hreadyout)
    else $error("transfer not answered after one wait state");

  read_back_a: assert property (
    bus.wr && bus.slot == vcr_pkg::SLOT_CHAN_PDN ##1 !bus.wr [*2]
      ##1 i_hsel && i_htrans[1] && i_hready && !i_hwrite &&
      vcr_pkg::slot_of(i_haddr) == vcr_pkg::SLOT_CHAN_PDN
      |-> ##2 o_hrdata == {16'h0000, $past(bus.wdata, 5)})
    else $error("read back differs from written word");

  cw_mode_c: cover property (wr_clk ##1 o_signal_path_select);
  all_pdn_c: cover property (wr_pdn ##1 o_channel_powerdown == 16'hFFFF);
  ratio_1x_c: cover property (o_doppler_clock_ratio == 2'h3);
  phase_max_c: cover property (vcr_pkg::phase_of(o_mixer_phase, 4'h0) == 4'hF);

endmodule

// [vcr_bank_tb.sv]
// vcr_bank_tb: self-checking testbench for the analog channel register bank
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0]  idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } vcr_row_t;

  logic         clk;
  logic         srst;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hready;
  logic         hresp;
  logic [31:0]  hrdata;
  logic         path_sel;
  logic         tgc_on;
  logic [1:0]   ratio;
  logic         base_type;
  logic         fast_type;
  logic [2:0]   cw_forced;
  logic [63:0]  phase;
  logic [15:0]  chan_pdn;
  logic [3:0]   pdn_bits;
  logic [1:0]   lpf_corner;
  logic         hpf_dis;
  logic [1:0]   hpf_corner;
  logic         low_pwr;
  logic         med_pwr;
  logic [3:0]   sw_dis;
  logic         ext_sw_dis;
  logic [103:0] flds;
  logic [31:0]  rd;
  logic [15:0]  cfg;
  int           error_cnt;
  int           checks;
  vcr_row_t     rows [11];

  localparam logic [2:0] SZ_WORD = {1'b0, vcr_pkg::HSIZE_WORD};

  assign flds = {path_sel, ratio, base_type, fast_type, cw_forced, phase, chan_pdn, pdn_bits,
                 lpf_corner, hpf_dis, hpf_corner, low_pwr, med_pwr, sw_dis, ext_sw_dis};

  vcr_bank dut (
    .i_clk                        (clk),
    .i_srst                       (srst),
    .i_hsel                       (hsel),
    .i_haddr                      (haddr),
    .i_htrans                     (htrans),
    .i_hwrite                     (hwrite),
    .i_hsize                      (hsize),
    .i_hwdata                     (hwdata),
    .i_hready                     (hready),
    .o_hreadyout                  (hready),
    .o_hresp                      (hresp),
    .o_hrdata                     (hrdata),
    .o_signal_path_select         (path_sel),
    .o_tgc_active                 (tgc_on),
    .o_doppler_clock_ratio        (ratio),
    .o_base_rate_clock_input_type (base_type),
    .o_fast_rate_clock_input_type (fast_type),
    .o_lna_gain_fixed             (cw_forced[2]),
    .o_attenuator_disable         (cw_forced[1]),
    .o_lowpass_disable            (cw_forced[0]),
    .o_mixer_phase                (phase),
    .o_channel_powerdown          (chan_pdn),
    .o_fast_powerdown             (pdn_bits[0]),
    .o_global_powerdown           (pdn_bits[1]),
    .o_lna_powerdown              (pdn_bits[2]),
    .o_filter_powerdown           (pdn_bits[3]),
    .o_lowpass_corner             (lpf_corner),
    .o_lna_highpass_disable       (hpf_dis),
    .o_lna_highpass_corner        (hpf_corner),
    .o_low_power_mode             (low_pwr),
    .o_medium_power_mode          (med_pwr),
    .o_switch_disable             (sw_dis),
    .o_ext_switch_disable         (ext_sw_dis)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // one single transfer; the printed index times four is the byte address
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     input logic [2:0] sz, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    hsize  <= sz;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {16'h0000, wd};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    data = hrdata;
    if (n >= 50)
      chk(1'b0, 1'b1, "bus answer timed out");
    chk(hresp, 1'b0, "response not okay");
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #50us;
    error_cnt++;
    results();
  end

  initial
  begin
    error_cnt = 0;
    checks    = 0;
    srst      = 1'b1;
    hsel      = 1'b0;
    haddr     = 32'h00000000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h0;
    hwdata    = 32'h00000000;
    rows = '{'{8'hC0, 16'hFFEA, 16'h000A}, '{8'hC1, 16'h4321, 16'h4321},
             '{8'hC2, 16'h8765, 16'h8765}, '{8'hC3, 16'hCBA9, 16'hCBA9},
             '{8'hC4, 16'h0FED, 16'h0FED}, '{8'hC5, 16'hA5C3, 16'hA5C3},
             '{8'hC6, 16'hFFFF, 16'h000F}, '{8'hC7, 16'hFFFF, 16'h0F80},
             '{8'hC8, 16'hFFFF, 16'h1000}, '{8'hCE, 16'hFFFF, 16'h4000},
             '{8'hE6, 16'hFFFF, 16'h001F}};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(flds, 104'h0, "fields after reset");
    chk(tgc_on, 1'b1, "time-gain path after reset");
    // bench acts as host with the gain-coefficient write gate already cleared
    foreach (rows[i])
    begin
      ahb(1'b0, rows[i].idx, 16'h0000, SZ_WORD, rd);
      chk(rd, 32'h00000000, "register not zero after reset");
      ahb(1'b1, rows[i].idx, rows[i].wdata, SZ_WORD, rd);
      ahb(1'b0, rows[i].idx, 16'h0000, SZ_WORD, rd);
      chk(rd, {16'h0000, rows[i].rdata}, "readback");
    end
    chk(phase, 64'h0FEDCBA987654321, "mixer phase nibbles");
    chk(phase[3:0], 4'h1, "channel one phase code");
    chk(phase[63:60], 4'h0, "channel sixteen phase code");
    chk(chan_pdn, 16'hA5C3, "channel power-down bits");
    chk({pdn_bits, lpf_corner, hpf_dis, hpf_corner, low_pwr, med_pwr, sw_dis, ext_sw_dis},
        16'hFFFF, "power, filter and switch fields");
    $display("test table done");
    for (int r = 0; r < 4; r++)
    begin
      cfg = {11'h000, r[0], ~r[0], r[1:0], r[1]};
      ahb(1'b1, 8'hC0, cfg, SZ_WORD, rd);
      chk(ratio, r[1:0], "clock ratio code");
      chk(base_type, r[0], "base clock input type");
      chk(fast_type, !r[0], "fast clock input type");
      chk({path_sel, tgc_on}, {r[1], ~r[1]}, "path select exclusive");
      chk(cw_forced, {3{r[1]}}, "doppler path forcing");
    end
    $display("test clock config done");
    ahb(1'b1, 8'hC9, 16'hFFFF, SZ_WORD, rd);
    ahb(1'b0, 8'hC9, 16'h0000, SZ_WORD, rd);
    chk(rd, 32'h00000000, "unmapped read");
    ahb(1'b1, 8'hC5, 16'h1234, 3'h0, rd);
    ahb(1'b0, 8'hC5, 16'h0000, SZ_WORD, rd);
    chk(rd, 32'h0000A5C3, "byte write must not store");
    ahb(1'b0, 8'hCE, 16'h0000, SZ_WORD, rd);
    chk(rd, 32'h00004000, "neighbour kept");
    $display("test refusals done");
    // distinct patterns so swapped fields cannot hide behind all ones
    ahb(1'b1, 8'hC6, 16'h0005, SZ_WORD, rd);
    ahb(1'b1, 8'hC7, 16'h0A80, SZ_WORD, rd);
    ahb(1'b1, 8'hE6, 16'h0015, SZ_WORD, rd);
    chk(pdn_bits, 4'h5, "power-down bit order");
    chk({lpf_corner, hpf_dis, hpf_corner}, 5'h0E, "filter field order");
    chk({sw_dis, ext_sw_dis}, 5'h0B, "switch field order");
    $display("test field order done");
    // second reset in mid-run clears every register field again and sets tgc_on
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(flds, 104'h0, "fields after second reset");
    chk(tgc_on, 1'b1, "time-gain path after second reset");
    ahb(1'b0, 8'hC1, 16'h0000, SZ_WORD, rd);
    chk(rd, 32'h00000000, "phase register after second reset");
    $display("test mid-run reset done");
    results();
  end
endmodule
